// ===== core/sharb_regs.svh
// Timing, code and field constants for the bus hand-off arbiter
`ifndef SHARB_REGS_SVH
`define SHARB_REGS_SVH
`define SHARB_REQ_IDLE      2'h0
`define SHARB_REQ_NORMAL    2'h1
`define SHARB_REQ_PREEMPT   2'h2
`define SHARB_ACK_NONE      2'h0
`define SHARB_ACK_DONE      2'h1
`define SHARB_OCTA_LAST     1'h1
`define SHARB_LONG_PHASE2   1'h1
`define SHARB_FIRST_OCTA    1'h0
`endif

// ===== core/sharb_pkg.sv
// Types shared by the bus hand-off arbiter files
package sharb_pkg;
  typedef enum logic [2:0] {
    sharb_cpu_own_type_e  = 3'b000,
    sharb_grant_wait      = 3'b001,
    sharb_dma_own         = 3'b010,
    sharb_released        = 3'b011,
    sharb_cpu_restore     = 3'b100,
    sharb_cpu_start       = 3'b101
  } sharb_state_type;

  // Outputs toward CPU, DMA chip and cache, bundled
  typedef struct packed {
    logic hold_req;
    logic grant;
    logic data_oe;
    logic tag_oe;
    logic cpu_drv_en;
    logic cpu_go;
  } sharb_ctl_type;

  // One cache write step request and its invalidate flag
  typedef struct packed {
    logic valid;
    logic invalidate;
  } sharb_wreq_type;
endpackage

// ===== core/sharb_long_write.sv
// Cache write pacing: normal or two-cycle long octaword writes
`timescale 1ns/1ps
`include "sharb_regs.svh"
module sharb_long_write (
  input  wire logic                clk_i,      // System clock
  input  wire logic                arst_n_i,   // Async reset, low
  input  wire logic                ce_i,       // Clock enable
  input  wire logic                long_sel_i, // Long write select
  input  wire sharb_pkg::sharb_wreq_type wreq_i, // Octaword request
  output logic                     wr_done_o,  // Octaword written
  output logic                     addr4_o,    // Cache data addr bit
  output logic                     pulse_o     // Long write pulse
);
  logic phase_ff, nxt_phase;
  logic addr4_ff, nxt_addr4;
  logic pulse_ff, nxt_pulse;
  logic done_ff,  nxt_done;

  // Next-value logic for the write pacer
  always_comb begin
    nxt_phase = phase_ff;
    nxt_addr4 = addr4_ff;
    nxt_pulse = 1'b0;
    nxt_done  = 1'b0;
    if (wreq_i.valid) begin
      if (!long_sel_i || wreq_i.invalidate) begin
        nxt_done  = 1'b1;
        nxt_addr4 = ~addr4_ff;
      end else if (phase_ff != `SHARB_LONG_PHASE2) begin
        nxt_phase = `SHARB_LONG_PHASE2;
        nxt_pulse = 1'b1;
      end else begin
        // address held both cycles, flips after
        nxt_phase = ~`SHARB_LONG_PHASE2;
        nxt_done  = 1'b1;
        nxt_addr4 = ~addr4_ff;
      end
    end else begin
      nxt_addr4 = `SHARB_FIRST_OCTA; // Each burst starts on low octaword
      nxt_phase = ~`SHARB_LONG_PHASE2;
    end
  end

  // State registers, frozen while the enable is low
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_ff <= 1'b0;
      addr4_ff <= 1'b0;
      pulse_ff <= 1'b0;
      done_ff  <= 1'b0;
    end else if (ce_i) begin
      phase_ff <= nxt_phase;
      addr4_ff <= nxt_addr4;
      pulse_ff <= nxt_pulse;
      done_ff  <= nxt_done;
    end
  end

  assign wr_done_o = done_ff;
  assign addr4_o   = addr4_ff;
  assign pulse_o   = pulse_ff;
endmodule

// ===== core/sharb_arbiter.sv
// System bus and cache hand-off arbiter with DMA preemption
`timescale 1ns/1ps
`include "sharb_regs.svh"
module sharb_arbiter (
  input  wire logic       clk_i,                  // System clock, 250 MHz
  input  wire logic       arst_n_i,               // Async reset, low
  input  wire logic       ce_i,                   // Clock enable
  input  wire logic       cpu_hold_acknowledge_i, // CPU hold ack (pin)
  input  wire logic [1:0] dma_request_code_i,     // DMA request code (pin)
  input  wire logic       cpu_request_i,          // CPU wants the bus
  input  wire logic       cpu_io_read_i,          // CPU op is an I/O read
  input  wire logic       allow_release_i,        // Cache release allowed
  input  wire logic       dma_start_i,            // DMA command seen
  input  wire logic       dma_octa_i,             // DMA octaword step
  input  wire logic       dma_invalidate_i,       // DMA write invalidate
  input  wire logic       cache_long_write_select_i, // Long write mode
  output logic            cpu_hold_request_o,     // Hold request to CPU
  output logic            dma_bus_grant_o,        // Grant to DMA chip
  output logic            cache_data_output_enable_o, // Cache data OE
  output logic            cache_tag_output_enable_o,  // Cache tag OE
  output logic [1:0]      dma_cycle_acknowledge_o,    // DMA cycle ack
  output logic            cpu_data_drive_o,       // Re-drive CPU data
  output logic            cpu_go_o,               // CPU op may proceed
  output logic            cache_data_address_bit_o, // Cache addr bit 4
  output logic            cache_long_write_pulse_o  // Long write pulse
);
  // Three-stage synchronisers for pin inputs
  logic [2:0] hack_sync_ff, nxt_hack_sync;
  logic [1:0] req_s1_ff, req_s2_ff, req_s3_ff;
  logic [1:0] nxt_req_s1, nxt_req_s2, nxt_req_s3;
  logic       hack_ff, nxt_hack;
  logic [1:0] req_ff, nxt_req;

  always_comb begin
    nxt_hack_sync = {hack_sync_ff[1:0], cpu_hold_acknowledge_i};
    nxt_req_s1    = dma_request_code_i;
    nxt_req_s2    = req_s1_ff;
    nxt_req_s3    = req_s2_ff;
    // Only count a change once stages two and three agree
    nxt_hack = (hack_sync_ff[1] == hack_sync_ff[2]) ?
               hack_sync_ff[2] : hack_ff;
    nxt_req  = (req_s2_ff == req_s3_ff) ? req_s3_ff : req_ff;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hack_sync_ff <= 3'h0;
      req_s1_ff    <= 2'h0;
      req_s2_ff    <= 2'h0;
      req_s3_ff    <= 2'h0;
      hack_ff      <= 1'b0;
      req_ff       <= 2'h0;
    end else if (ce_i) begin
      hack_sync_ff <= nxt_hack_sync;
      req_s1_ff    <= nxt_req_s1;
      req_s2_ff    <= nxt_req_s2;
      req_s3_ff    <= nxt_req_s3;
      hack_ff      <= nxt_hack;
      req_ff       <= nxt_req;
    end
  end

  // Cache write pacer for DMA octawords
  sharb_pkg::sharb_wreq_type wreq;
  logic wr_done;
  logic last_octa;
  logic addr4_w;
  logic pulse_w;
  sharb_pkg::sharb_state_type st_ff;

  // Gated on the second octaword so no third write slips in
  assign wreq.valid      = dma_octa_i && !last_octa &&
                           (st_ff == sharb_pkg::sharb_dma_own);
  assign wreq.invalidate = dma_invalidate_i;

  sharb_long_write u_wr (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .long_sel_i (cache_long_write_select_i),
    .wreq_i     (wreq),
    .wr_done_o  (wr_done),
    .addr4_o    (addr4_w),
    .pulse_o    (pulse_w)
  );

  // Arbitration state
  sharb_pkg::sharb_state_type nxt_st;
  sharb_pkg::sharb_ctl_type   ctl_ff, nxt_ctl;
  logic       octa_cnt_ff, nxt_octa_cnt;
  logic       preempt_ff, nxt_preempt;
  logic       io_read_ff, nxt_io_read;
  logic [1:0] ack_ff, nxt_ack;
  logic       addr4_ff;
  logic       preempt_req;
  logic       normal_req;

  assign preempt_req = (req_ff == `SHARB_REQ_PREEMPT);
  assign normal_req  = (req_ff == `SHARB_REQ_NORMAL);
  assign last_octa   = wr_done && (octa_cnt_ff == `SHARB_OCTA_LAST);

  // Next-state and output logic
  always_comb begin
    nxt_st       = st_ff;
    nxt_ctl      = ctl_ff;
    nxt_octa_cnt = octa_cnt_ff;
    nxt_preempt  = preempt_ff;
    nxt_io_read  = io_read_ff;
    nxt_ack      = `SHARB_ACK_NONE;
    nxt_ctl.cpu_drv_en = 1'b0;
    nxt_ctl.cpu_go     = 1'b0;
    case (st_ff)
      sharb_pkg::sharb_cpu_own_type_e: begin
        // preempt raises hold and grant next cycle
        if (preempt_req || normal_req) begin
          nxt_preempt      = preempt_req;
          nxt_io_read      = cpu_io_read_i;
          nxt_ctl.hold_req = 1'b1;
          nxt_ctl.grant    = 1'b1;
          nxt_st           = sharb_pkg::sharb_grant_wait;
        end
      end
      sharb_pkg::sharb_grant_wait: begin
        // DMA chip itself waits for this ack
        if (hack_ff) begin
          nxt_ctl.data_oe = 1'b1;
          nxt_ctl.tag_oe  = 1'b1;
          nxt_octa_cnt    = 1'b0;
          nxt_st          = sharb_pkg::sharb_dma_own;
        end
      end
      sharb_pkg::sharb_dma_own: begin
        if (wr_done) begin
          nxt_octa_cnt = ~octa_cnt_ff;
        end
        if (last_octa) begin
          nxt_ack = `SHARB_ACK_DONE;
          // A normal request re-arbitrates from CPU ownership
          if (!preempt_req) begin
            nxt_ctl.grant   = 1'b0;
            nxt_ctl.data_oe = 1'b0;
            nxt_ctl.tag_oe  = 1'b0;
            nxt_st = sharb_pkg::sharb_cpu_restore;
          end
        // release cache to CPU during DMA
        end else if (dma_start_i && allow_release_i && cpu_request_i &&
                     !preempt_ff) begin
          nxt_ctl.grant    = 1'b0;
          nxt_ctl.hold_req = 1'b0;
          nxt_ctl.data_oe  = 1'b0;
          nxt_ctl.tag_oe   = 1'b0;
          nxt_st = sharb_pkg::sharb_released;
        end
      end
      sharb_pkg::sharb_released: begin
        // force CPU off to reclaim cache
        if (preempt_req || normal_req) begin
          nxt_preempt      = preempt_req;
          nxt_io_read      = cpu_io_read_i;
          nxt_ctl.hold_req = 1'b1;
          nxt_ctl.grant    = 1'b1;
          nxt_st = sharb_pkg::sharb_grant_wait;
        // CPU wins once it has let go; go follows the ack one cycle later
        end else if (!hack_ff && cpu_request_i) begin
          nxt_ack = `SHARB_ACK_DONE;
          nxt_st  = sharb_pkg::sharb_cpu_start;
        end
      end
      sharb_pkg::sharb_cpu_start: begin
        // CPU processing starts after the ack
        nxt_ctl.cpu_go = 1'b1;
        nxt_st = sharb_pkg::sharb_cpu_own_type_e;
      end
      sharb_pkg::sharb_cpu_restore: begin
        nxt_ctl.hold_req = 1'b0;
        // grant and hold ack low: resume
        if (!hack_ff) begin
          nxt_ctl.cpu_drv_en = preempt_ff && io_read_ff;
          nxt_ctl.cpu_go     = 1'b1;
          nxt_preempt        = 1'b0;
          nxt_st = sharb_pkg::sharb_cpu_own_type_e;
        end
      end
      default: begin
        nxt_st = sharb_pkg::sharb_cpu_own_type_e;
      end
    endcase
  end

  // Registered state; outputs except the long write pulse come straight from these
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff       <= sharb_pkg::sharb_cpu_own_type_e;
      ctl_ff      <= '0;
      octa_cnt_ff <= 1'b0;
      preempt_ff  <= 1'b0;
      io_read_ff  <= 1'b0;
      ack_ff      <= 2'h0;
      addr4_ff    <= 1'b0;
    end else if (ce_i) begin
      st_ff       <= nxt_st;
      ctl_ff      <= nxt_ctl;
      octa_cnt_ff <= nxt_octa_cnt;
      preempt_ff  <= nxt_preempt;
      io_read_ff  <= nxt_io_read;
      ack_ff      <= nxt_ack;
      addr4_ff    <= addr4_w; // Lags a cycle: spans pulse and second cycle
    end
  end

  assign cpu_hold_request_o         = ctl_ff.hold_req;
  assign dma_bus_grant_o            = ctl_ff.grant;
  assign cache_data_output_enable_o = ctl_ff.data_oe;
  assign cache_tag_output_enable_o  = ctl_ff.tag_oe;
  assign cpu_data_drive_o           = ctl_ff.cpu_drv_en;
  assign cpu_go_o                   = ctl_ff.cpu_go;
  assign dma_cycle_acknowledge_o    = ack_ff;
  assign cache_data_address_bit_o   = addr4_ff;
  assign cache_long_write_pulse_o   = pulse_w; // Pacer flop, unstaged
endmodule

// ===== test/sharb_arbiter_props.sv
// Port checks for the bus hand-off arbiter
`timescale 1ns/1ps
`include "sharb_regs.svh"
module sharb_arbiter_props (
  input wire logic       clk_i,                      // Clock
  input wire logic       arst_n_i,                   // Reset, low
  input wire logic       cpu_hold_acknowledge_i,     // Hold ack
  input wire logic       cpu_hold_request_o,         // Hold request
  input wire logic       dma_bus_grant_o,            // Grant
  input wire logic       cache_data_output_enable_o, // Data OE
  input wire logic       cache_tag_output_enable_o,  // Tag OE
  input wire logic [1:0] dma_cycle_acknowledge_o,    // DMA ack
  input wire logic       cpu_go_o,                   // CPU go
  input wire logic       cache_data_address_bit_o,   // Addr bit 4
  input wire logic       cache_long_write_pulse_o    // Long pulse
);
  default clocking dflt_cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // Bus fully back with the CPU
  sequence cpu_owns_s;
    !cpu_hold_request_o && !dma_bus_grant_o;
  endsequence
  // Grant never runs ahead of the hold request
  grant_with_hold_a: assert property (
    $rose(dma_bus_grant_o) |-> cpu_hold_request_o) else $error("lone grant");
  // Cache outputs wait for the CPU to let go
  oe_after_hack_a: assert property (
    $rose(cache_data_output_enable_o) |-> $past(cpu_hold_acknowledge_i, 2)
    && cache_tag_output_enable_o) else $error("early cache enable");
  oe_in_grant_a: assert property (
    cache_data_output_enable_o |-> dma_bus_grant_o) else $error("stray OE");
  ack_drops_a: assert property (
    dma_cycle_acknowledge_o == `SHARB_ACK_DONE |-> !dma_bus_grant_o
    && !cache_data_output_enable_o) else $error("ack with grant");
  ack_pulse_a: assert property (
    dma_cycle_acknowledge_o == `SHARB_ACK_DONE |=>
    dma_cycle_acknowledge_o == `SHARB_ACK_NONE) else $error("long ack");
  // Hold may trail the grant drop by one cycle at most
  hold_follow_a: assert property (
    $fell(dma_bus_grant_o) |-> ##[0:1] !cpu_hold_request_o)
    else $error("hold stuck");
  go_released_a: assert property (
    cpu_go_o |-> !cpu_hold_acknowledge_i ##0 cpu_owns_s ##1 !cpu_go_o)
    else $error("go while held");
  // Released-cache ack is the CPU win; it starts the next cycle
  rel_ack_go_a: assert property (
    dma_cycle_acknowledge_o == `SHARB_ACK_DONE &&
    !$past(cache_data_output_enable_o) |=> cpu_go_o)
    else $error("no CPU start");
  long_pulse_a: assert property (
    cache_long_write_pulse_o |=> !cache_long_write_pulse_o
    && $stable(cache_data_address_bit_o)) else $error("long pulse");
endmodule

// ===== test/sharb_far_model.sv
// Far side model: CPU hold handshake and DMA chip request side
`timescale 1ns/1ps
`include "sharb_regs.svh"
module sharb_far_model #(
  parameter int HACK_DLY = 3  // Hold ack lag, 2 or more
) (
  input  wire logic       clk_i,      // Clock
  input  wire logic       arst_n_i,   // Reset, low
  input  wire logic       hold_req_i, // Hold request
  input  wire logic       grant_i,    // DMA grant
  input  wire logic       oe_i,       // Cache data OE
  input  wire logic [1:0] kick_i,     // Code to raise
  output logic            hack_o,     // Hold ack
  output logic [1:0]      req_code_o, // Request code
  output logic            start_o,    // DMA command
  output logic            octa_o      // Octaword step
);
  logic [HACK_DLY-1:0] hack_ff;
  logic [1:0]          code_ff;
  // CPU answers and releases hold after a fixed lag
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hack_ff <= '0;
      code_ff <= `SHARB_REQ_IDLE;
    end else begin
      hack_ff <= {hack_ff[HACK_DLY-2:0], hold_req_i};
      // code held until on bus, never mid-write
      if (kick_i != `SHARB_REQ_IDLE)
        code_ff <= kick_i;
      else if (grant_i && hack_o)
        code_ff <= `SHARB_REQ_IDLE;
    end
  end
  assign hack_o     = hack_ff[HACK_DLY-1];
  assign req_code_o = code_ff;
  // works only with grant and hold ack
  assign start_o    = grant_i && hack_o;
  assign octa_o     = grant_i && hack_o && oe_i;
endmodule

// ===== test/sharb_arbiter_tb_top.sv
// Self-checking bench for the bus hand-off arbiter
`timescale 1ns/1ps
`include "sharb_regs.svh"
module sharb_arbiter_tb_top;
  typedef struct {
    logic sel, inv, io;
    int   pulses, oes;
  } sharb_row_type;
  // Long mode, invalidate, I/O read; long pulses, OE-high cycles
  sharb_row_type rows [4] = '{'{1'h0, 1'h0, 1'h1, 0, 3},
    '{1'h1, 1'h0, 1'h0, 2, 5}, '{1'h1, 1'h1, 1'h1, 0, 3},
    '{1'h0, 1'h1, 1'h0, 0, 3}};
  localparam int GNT = 0, HLD = 1, DOE = 2, GO = 3;
  logic       clk_i = 1'h0;
  logic       arst_n = 1'h0;
  logic       creq = 1'h0, io_rd = 1'h0, allow = 1'h0;
  logic       lsel = 1'h0, inval = 1'h0;
  logic       ce = 1'h1;
  logic [1:0] kick = 2'h0;
  logic       hack, start, octa, hold, grant, doe, toe, drv, go, a4, pls;
  logic [1:0] code, ack;
  int         errors = 0;
  int         check_count = 0;
  int         n_pls, n_oe, n_go, n_drv;
  // Free-running 250 MHz clock
  always #2 clk_i = ~clk_i;
  sharb_arbiter dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n), .ce_i(ce),
    .cpu_hold_acknowledge_i(hack), .dma_request_code_i(code),
    .cpu_request_i(creq), .cpu_io_read_i(io_rd), .allow_release_i(allow),
    .dma_start_i(start), .dma_octa_i(octa), .dma_invalidate_i(inval),
    .cache_long_write_select_i(lsel), .cpu_hold_request_o(hold),
    .dma_bus_grant_o(grant), .cache_data_output_enable_o(doe),
    .cache_tag_output_enable_o(toe), .dma_cycle_acknowledge_o(ack),
    .cpu_data_drive_o(drv), .cpu_go_o(go), .cache_data_address_bit_o(a4),
    .cache_long_write_pulse_o(pls));
  sharb_far_model #(.HACK_DLY(3)) far_u (
    .clk_i(clk_i), .arst_n_i(arst_n), .hold_req_i(hold), .grant_i(grant),
    .oe_i(doe), .kick_i(kick), .hack_o(hack), .req_code_o(code),
    .start_o(start), .octa_o(octa));
  // Tally pulses and OE-high cycles, sampled mid-cycle where settled
  always @(negedge clk_i) begin
    n_pls += int'(pls === 1'h1);
    n_oe  += int'(doe === 1'h1);
    n_go  += int'(go === 1'h1);
    n_drv += int'(drv === 1'h1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %0h, want %0h", $time, got, exp);
    end
  endtask
  // Bounded wait on one output level; running out is a mismatch
  task automatic wait_for(input int idx, input logic lvl);
    int n;
    logic [3:0] lv;
    n = 0;
    lv = {go, doe, hold, grant};
    while (lv[idx] !== lvl && n < 100) begin
      @(negedge clk_i);
      n++;
      lv = {go, doe, hold, grant};
    end
    chk(lv[idx], lvl);
  endtask
  // Request code raised for one cycle; the model holds it
  task automatic send(input logic [1:0] c);
    kick = c;
    @(negedge clk_i);
    kick = `SHARB_REQ_IDLE;
  endtask
  task automatic give_verdict();
    $display("errors %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk_i);
    chk({hold, grant, doe, toe, ack, drv, go, pls}, 32'h0);
    arst_n = 1'h1;
    repeat (2) @(negedge clk_i);
    // Preempt a CPU op once per table row, an I/O read where the row sets it
    foreach (rows[i]) begin
      {lsel, inval, io_rd, creq} = {rows[i].sel, rows[i].inv, rows[i].io, 1'h1};
      {n_pls, n_oe, n_go, n_drv} = 128'h0;
      send(`SHARB_REQ_PREEMPT);
      wait_for(HLD, 1'h1);
      chk(grant, 1'h1);
      wait_for(GO, 1'h1);
      repeat (2) @(negedge clk_i);
      creq = 1'h0;
      chk(n_pls, rows[i].pulses);
      chk(n_oe, rows[i].oes);
      chk(n_drv, rows[i].io);
      chk(n_go, 1);
      repeat (4) @(negedge clk_i);
    end
    // Cache released mid-DMA: CPU wins it first, a preempt reclaims next
    {allow, creq} = 2'h3;
    for (int k = 0; k < 2; k++) begin
      send(`SHARB_REQ_NORMAL);
      wait_for(GNT, 1'h1);
      wait_for(GNT, 1'h0);
      @(negedge clk_i);
      chk(hold, 1'h0);
      if (k == 0)
        wait_for(GO, 1'h1);
    end
    allow = 1'h0;
    send(`SHARB_REQ_PREEMPT);
    wait_for(GNT, 1'h1);
    chk(hold, 1'h1);
    wait_for(DOE, 1'h1);
    chk(toe, 1'h1);
    // Enable low must freeze the granted state
    ce = 1'h0;
    repeat (8) @(negedge clk_i);
    chk({grant, doe, ack}, 4'hc);
    ce = 1'h1;
    wait_for(GNT, 1'h0);
    give_verdict();
  end
  // Cut a hang short far beyond the expected run
  initial begin
    #20000;
    errors++;
    $display("unexpected at %0t: run hung", $time);
    give_verdict();
  end
endmodule
bind sharb_arbiter sharb_arbiter_props chk_u (
  .clk_i(clk_i), .arst_n_i(arst_n_i),
  .cpu_hold_acknowledge_i(cpu_hold_acknowledge_i),
  .cpu_hold_request_o(cpu_hold_request_o), .dma_bus_grant_o(dma_bus_grant_o),
  .cache_data_output_enable_o(cache_data_output_enable_o),
  .cache_tag_output_enable_o(cache_tag_output_enable_o),
  .dma_cycle_acknowledge_o(dma_cycle_acknowledge_o), .cpu_go_o(cpu_go_o),
  .cache_data_address_bit_o(cache_data_address_bit_o),
  .cache_long_write_pulse_o(cache_long_write_pulse_o));
